// file: src/integration_timer.sv
`default_nettype none
module integration_timer
  import light_sensor_pkg::*;
#(
  parameter int CYCLES = INTEG_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output var  logic done
);
  logic [CNT_W-1:0] count;

  // restarts from zero on every power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      done  <= 1'b0;
    end else if (count == CNT_W'(CYCLES - 1)) begin
      count <= '0;
      done  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      done  <= 1'b0;
    end
  end
endmodule : integration_timer
`default_nettype wire

// file: src/light_sensor_core.sv
`default_nettype none
module light_sensor_core
  import light_sensor_pkg::*;
#(
  parameter int INTEG_CYCLES_P = INTEG_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [15:0]       broadband_sample,
  input  wire logic [15:0]       infrared_sample,
  output var  logic              analog_gain,
  output var  logic [1:0]        analog_integ_sel,
  output var  logic              powered,
  output var  logic              int_out,
  output var  logic              int_oe
);

  logic [7:0]  control;
  logic [7:0]  timing;
  logic [15:0] thr_low;
  logic [15:0] thr_high;
  logic [7:0]  int_ctl;
  logic [7:0]  command;
  logic [15:0] channel0_result;
  logic [15:0] channel1_result;
  logic [7:0]  ch0_shadow;
  logic [7:0]  ch1_shadow;
  logic        int_pending;
  logic [15:0] bb_meta;
  logic [15:0] bb_sync;
  logic [15:0] ir_meta;
  logic [15:0] ir_sync;
  logic [15:0] bb_prev;
  logic [15:0] bb_stable;
  logic [15:0] ir_prev;
  logic [15:0] ir_stable;
  logic        conv_done;
  logic        fire;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic [3:0]  idx;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [1:0]  interrupt_style_select;
  logic        run;
  logic        next_pending;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] i;
    i = a[5:2];
    addr_mapped = (a[7:6] == 2'b00) && (a[1:0] == 2'b00) &&
                  (i != 4'h7) && (i != 4'h9) && (i != 4'hB);
  endfunction : addr_mapped

  function automatic logic [3:0] addr_index(input logic [ADDR_W-1:0] a);
    addr_index = a[5:2];
  endfunction : addr_index

  assign setup                  = psel && !penable;
  assign access                 = psel && penable && pready;
  assign idx                    = addr_index(paddr);
  assign mapped                 = addr_mapped(paddr);
  assign wr_en                  = access && pwrite && mapped;
  assign wbyte                  = pwdata[7:0];
  assign interrupt_style_select = int_ctl[STYLE_MSB:STYLE_LSB];
  assign run                    = (control[1:0] == POWER_UP);

  // level inputs from the converter domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_meta <= DATA_RESET;
      bb_sync <= DATA_RESET;
      ir_meta <= DATA_RESET;
      ir_sync <= DATA_RESET;
    end else begin
      bb_meta <= broadband_sample;
      bb_sync <= bb_meta;
      ir_meta <= infrared_sample;
      ir_sync <= ir_meta;
    end
  end

  // word taken only once two successive synced copies agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_prev   <= DATA_RESET;
      bb_stable <= DATA_RESET;
      ir_prev   <= DATA_RESET;
      ir_stable <= DATA_RESET;
    end else begin
      bb_prev <= bb_sync;
      ir_prev <= ir_sync;
      if (bb_sync == bb_prev) begin
        bb_stable <= bb_sync;
      end
      if (ir_sync == ir_prev) begin
        ir_stable <= ir_sync;
      end
    end
  end

  // APB handshake: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // read data prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite && mapped) begin
      unique case (idx)
        IDX_CONTROL:    prdata <= {24'h000000, control};
        IDX_TIMING:     prdata <= {24'h000000, timing};
        IDX_THR_LOW_L:  prdata <= {24'h000000, thr_low[7:0]};
        IDX_THR_LOW_H:  prdata <= {24'h000000, thr_low[15:8]};
        IDX_THR_HIGH_L: prdata <= {24'h000000, thr_high[7:0]};
        IDX_THR_HIGH_H: prdata <= {24'h000000, thr_high[15:8]};
        IDX_INT_CTL:    prdata <= {24'h000000, int_ctl};
        IDX_COMMAND:    prdata <= {24'h000000, command};
        IDX_ID:         prdata <= {24'h000000, ID_VALUE};
        IDX_CH0_L:      prdata <= {24'h000000, channel0_result[7:0]};
        IDX_CH0_H:      prdata <= {24'h000000, ch0_shadow};
        IDX_CH1_L:      prdata <= {24'h000000, channel1_result[7:0]};
        IDX_CH1_H:      prdata <= {24'h000000, ch1_shadow};
        default:        prdata <= '0;
      endcase
    end else if (setup) begin
      prdata <= '0;
    end
  end

  // upper bytes frozen together with the low byte read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch0_shadow <= 8'h00;
      ch1_shadow <= 8'h00;
    end else if (setup && !pwrite && mapped) begin
      if (idx == IDX_CH0_L) begin
        ch0_shadow <= channel0_result[15:8];
      end
      if (idx == IDX_CH1_L) begin
        ch1_shadow <= channel1_result[15:8];
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CONTROL_RESET;
    end else if (wr_en && idx == IDX_CONTROL) begin
      control <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered <= 1'b0;
    end else begin
      powered <= run;
    end
  end

  // timing register steers the analog front end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing <= TIMING_RESET;
    end else if (wr_en && idx == IDX_TIMING) begin
      timing <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_gain      <= TIMING_RESET[GAIN_BIT];
      analog_integ_sel <= TIMING_RESET[INTEG_MSB:0];
    end else begin
      analog_gain      <= timing[GAIN_BIT];
      analog_integ_sel <= timing[INTEG_MSB:0];
    end
  end

  // threshold window, byte by byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_low  <= THR_RESET;
      thr_high <= THR_RESET;
    end else if (wr_en) begin
      unique case (idx)
        IDX_THR_LOW_L:  thr_low[7:0]   <= wbyte;
        IDX_THR_LOW_H:  thr_low[15:8]  <= wbyte;
        IDX_THR_HIGH_L: thr_high[7:0]  <= wbyte;
        IDX_THR_HIGH_H: thr_high[15:8] <= wbyte;
        default:        thr_low        <= thr_low;
      endcase
    end
  end

  // interrupt control, reserved bits kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ctl <= INT_CTL_RESET;
    end else if (wr_en && idx == IDX_INT_CTL) begin
      int_ctl <= wbyte & INT_CTL_MASK;
    end
  end

  // command register; clear bit is self-clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command <= COMMAND_RESET;
    end else if (wr_en && idx == IDX_COMMAND) begin
      command <= wbyte & ~(8'h01 << CLEAR_BIT);
    end
  end

  integration_timer #(
    .CYCLES (INTEG_CYCLES_P)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .done    (conv_done)
  );

  // both channels latched on the same integration end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel0_result <= DATA_RESET;
      channel1_result <= DATA_RESET;
    end else if (conv_done) begin
      channel0_result <= bb_stable;
      channel1_result <= ir_stable;
    end
  end

  persistence_filter u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .conv_done (conv_done),
    .result    (bb_stable),
    .thr_low   (thr_low),
    .thr_high  (thr_high),
    .persist   (int_ctl[PERSIST_MSB:0]),
    .fire      (fire)
  );

  // set wins over a clear in the same cycle
  always_comb begin
    next_pending = int_pending;
    if (wr_en && idx == IDX_COMMAND && wbyte[CLEAR_BIT]) begin
      next_pending = 1'b0;
    end
    if (fire && interrupt_style_select == STYLE_LEVEL) begin
      next_pending = 1'b1;
    end
    if (wr_en && idx == IDX_INT_CTL && wbyte[STYLE_MSB:STYLE_LSB] == STYLE_TEST) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pending <= 1'b0;
    end else begin
      int_pending <= next_pending;
    end
  end

  // open drain: data always low, enable pulls the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
    end else begin
      int_out <= 1'b0;
      int_oe  <= int_pending && (interrupt_style_select != STYLE_OFF);
    end
  end

endmodule : light_sensor_core
`default_nettype wire

// file: src/light_sensor_pkg.sv
`default_nettype none
package light_sensor_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0]  IDX_CONTROL       = 4'h0;
  localparam logic [3:0]  IDX_TIMING        = 4'h1;
  localparam logic [3:0]  IDX_THR_LOW_L     = 4'h2;
  localparam logic [3:0]  IDX_THR_LOW_H     = 4'h3;
  localparam logic [3:0]  IDX_THR_HIGH_L    = 4'h4;
  localparam logic [3:0]  IDX_THR_HIGH_H    = 4'h5;
  localparam logic [3:0]  IDX_INT_CTL       = 4'h6;
  localparam logic [3:0]  IDX_COMMAND       = 4'h8;
  localparam logic [3:0]  IDX_ID            = 4'hA;
  localparam logic [3:0]  IDX_CH0_L         = 4'hC;
  localparam logic [3:0]  IDX_CH0_H         = 4'hD;
  localparam logic [3:0]  IDX_CH1_L         = 4'hE;
  localparam logic [3:0]  IDX_CH1_H         = 4'hF;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  // control register
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  localparam logic [1:0]  POWER_UP          = 2'h3;
  // timing register
  localparam logic [7:0]  TIMING_RESET      = 8'h02;
  localparam int          GAIN_BIT          = 4;
  localparam int          INTEG_MSB         = 1;
  // interrupt control register
  localparam logic [7:0]  INT_CTL_RESET     = 8'h00;
  localparam logic [7:0]  INT_CTL_MASK      = 8'h3F;
  localparam int          STYLE_MSB         = 5;
  localparam int          STYLE_LSB         = 4;
  localparam int          PERSIST_MSB       = 3;
  localparam logic [1:0]  STYLE_OFF         = 2'h0;
  localparam logic [1:0]  STYLE_LEVEL       = 2'h1;
  localparam logic [1:0]  STYLE_TEST        = 2'h3;
  // command register
  localparam logic [7:0]  COMMAND_RESET     = 8'h00;
  localparam int          CLEAR_BIT         = 6;
  // other resets
  localparam logic [15:0] THR_RESET         = 16'h0000;
  localparam logic [15:0] DATA_RESET        = 16'h0000;
  // arbitrary identification value
  localparam logic [7:0]  ID_VALUE          = 8'h3C;
  // timing
  localparam longint      CLK_HZ            = 100_000_000;
  localparam longint      INTEG_TIME_MS     = 400;
  localparam int          INTEG_CYCLES      = int'(INTEG_TIME_MS * CLK_HZ / 1000);
  localparam int          CNT_W             = 26;
endpackage : light_sensor_pkg
`default_nettype wire

// file: src/persistence_filter.sv
`default_nettype none
module persistence_filter
  import light_sensor_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_done,
  input  wire logic [15:0] result,
  input  wire logic [15:0] thr_low,
  input  wire logic [15:0] thr_high,
  input  wire logic [3:0]  persist,
  output var  logic        fire
);
  logic [3:0] run_len;
  logic       outside;

  assign outside = (result < thr_low) || (result > thr_high);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len <= 4'h0;
      fire    <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (conv_done) begin
        if (persist == 4'h0) begin
          fire    <= 1'b1;
          run_len <= 4'h0;
        end else if (!outside) begin
          run_len <= 4'h0;
        end else if ((run_len + 4'h1) >= persist) begin
          fire    <= 1'b1;
          run_len <= 4'h0;
        end else begin
          run_len <= run_len + 4'h1;
        end
      end
    end
  end
endmodule : persistence_filter
`default_nettype wire

// file: verification/light_sensor_asserts.sv
`default_nettype none
module light_sensor_asserts
  import light_sensor_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              analog_gain,
  input wire logic [1:0]        analog_integ_sel,
  input wire logic              powered,
  input wire logic              int_out,
  input wire logic              int_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       wr;
  logic       bad;
  logic       pwon;
  logic       clr;
  logic [1:0] style_q;
  assign wr   = psel && penable && pready && pwrite;
  assign bad  = paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0 || paddr[5:2] inside {4'h7, 4'h9, 4'hB};
  assign pwon = wr && paddr == 8'h00 && pwdata[1:0] == 2'h3;
  assign clr  = wr && paddr == 8'h20 && pwdata[CLEAR_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      style_q <= 2'h0;
    end else if (wr && paddr == 8'h18) begin
      style_q <= pwdata[5:4];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  chk_ready_next: assert property (s_setup |=> s_access)
    else $error("access not answered");
  chk_slverr_map: assert property (s_setup ##1 s_access |-> pslverr == $past(bad))
    else $error("wrong error response");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_drain_only: assert property (int_out == 1'b0)
    else $error("interrupt pin driven high");
  chk_power_up: assert property (pwon |-> ##[1:2] powered)
    else $error("no power-up after control write");
  chk_power_cause: assert property ($rose(powered) |-> $past(pwon) || $past(pwon, 2))
    else $error("power-up without control write");
  chk_style_off: assert property (style_q == 2'h0 && $past(style_q) == 2'h0 |-> !int_oe)
    else $error("interrupt active while disabled");
  chk_level_hold: assert property ($fell(int_oe) |-> $past(clr) || $past(clr, 2) || $past(clr, 3)
                                   || style_q == 2'h0)
    else $error("interrupt dropped without clear");
  chk_test_set: assert property (wr && paddr == 8'h18 && pwdata[5:4] == 2'h3 |-> ##[1:2] int_oe)
    else $error("test mode did not assert");
  chk_gain_copy: assert property (wr && paddr == 8'h04 |-> ##2 analog_integ_sel == $past(pwdata[1:0], 2)
                                  && analog_gain == $past(pwdata[GAIN_BIT], 2))
    else $error("analog settings not applied");
  chk_clear_drop: assert property (clr && style_q[1] |-> ##2 !int_oe)
    else $error("clear did not release interrupt");
endmodule : light_sensor_asserts
bind light_sensor_core light_sensor_asserts light_sensor_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .analog_gain, .analog_integ_sel, .powered, .int_out, .int_oe
);
`default_nettype wire

// file: verification/light_sensor_conversion_interrupt_tb.sv
`default_nettype none
module light_sensor_conversion_interrupt_tb
  import light_sensor_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IC = 20;
  `define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", n, e, s); end end
  typedef struct {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic       s;
  } row_t;
  typedef struct {
    logic [3:0]  p;
    logic [15:0] b;
    logic [15:0] i;
    logic        f;
  } prow_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        analog_gain;
  logic [1:0]  analog_integ_sel;
  logic        powered;
  logic        int_out;
  logic        int_oe;
  logic        int_line;
  logic [15:0] bb;
  logic [15:0] ir;
  logic [15:0] broadband_sample;
  logic [15:0] infrared_sample;
  int          err_total;
  int          checks_done;
  row_t rows [20] = '{
    '{1'b0, 8'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'h02, 1'b0},
    '{1'b0, 8'h08, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h14, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h18, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h20, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h28, 8'h00, ID_VALUE, 1'b0}, '{1'b0, 8'h3C, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h1C, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h24, 8'h5A, 8'h00, 1'b1},
    '{1'b0, 8'h2A, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h28, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h28, 8'h00, ID_VALUE, 1'b0}, '{1'b1, 8'h18, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 8'h18, 8'h00, 8'h3F, 1'b0}, '{1'b1, 8'h20, 8'hC0, 8'h00, 1'b0},
    '{1'b0, 8'h20, 8'h00, 8'h80, 1'b0}, '{1'b1, 8'h04, 8'h12, 8'h00, 1'b0},
    '{1'b0, 8'h04, 8'h00, 8'h12, 1'b0}, '{1'b0, 8'h30, 8'h00, 8'h00, 1'b0}
  };
  // window 0100..0200; boundaries sit inside
  prow_t prows [5] = '{
    '{4'h1, 16'h0201, 16'h0150, 1'b1}, '{4'h2, 16'h00FF, 16'h0150, 1'b1},
    '{4'hF, 16'h0300, 16'h0150, 1'b1}, '{4'h1, 16'h0200, 16'h0150, 1'b0},
    '{4'h1, 16'h0100, 16'hFFFF, 1'b0}
  };
  light_sensor_core #(.INTEG_CYCLES_P(IC)) light_sensor_core_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .broadband_sample, .infrared_sample, .analog_gain, .analog_integ_sel, .powered, .int_out, .int_oe
  );
  sensor_front_model sensor_front_model_inst (
    .pclk, .bb_level(bb), .ir_level(ir), .int_out, .int_oe, .broadband_sample, .infrared_sample, .int_line
  );
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] r;
    logic       e;
    apb(1'b0, a, 8'h00, r, e);
    `CHK("read", x, r)
  endtask : rd
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #30000;
    err_total++;
    summarize();
  end
  initial begin
    logic [7:0] r;
    logic       e;
    int         t;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bb = 16'h1234;
    ir = 16'h5678;
    err_total = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    `CHK("sel", 2'h2, analog_integ_sel)
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      `CHK("err", rows[i].s, e)
      if (!rows[i].w) `CHK("reg", rows[i].e, r)
    end
    `CHK("gain", 1'b1, analog_gain)
    `CHK("off", 1'b0, powered)
    wr(8'h10, 8'hFF);
    wr(8'h14, 8'hFF);
    wr(8'h18, 8'h10);
    wr(8'h00, 8'h03);
    t = 0;
    while (int_oe !== 1'b1 && t < 100) begin
      @(posedge pclk);
      t++;
    end
    `CHK("first", 1'b1, t >= IC && t <= IC + 8)
    `CHK("line", 1'b0, int_line)
    `CHK("on", 1'b1, powered)
    rd(8'h30, 8'h34);
    bb <= 16'hABCD;
    repeat (IC + 5) @(posedge pclk);
    rd(8'h34, 8'h12);
    rd(8'h38, 8'h78);
    rd(8'h3C, 8'h56);
    rd(8'h30, 8'hCD);
    wr(8'h18, 8'h00);
    repeat (45) @(posedge pclk);
    `CHK("quiet", 1'b1, int_line)
    wr(8'h20, 8'h40);
    wr(8'h18, 8'h30);
    repeat (3) @(posedge pclk);
    `CHK("test", 1'b1, int_oe)
    repeat (45) @(posedge pclk);
    `CHK("hold", 1'b0, int_line)
    wr(8'h20, 8'h40);
    repeat (3) @(posedge pclk);
    `CHK("clear", 1'b0, int_oe)
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h01);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h02);
    foreach (prows[k]) begin
      wr(8'h00, 8'h00);
      wr(8'h20, 8'h40);
      bb <= prows[k].b;
      ir <= prows[k].i;
      wr(8'h18, {4'h1, prows[k].p});
      wr(8'h00, 8'h03);
      repeat (IC * prows[k].p - 5) @(posedge pclk);
      `CHK("early", 1'b0, int_oe)
      repeat (13) @(posedge pclk);
      `CHK("fire", prows[k].f, int_oe)
    end
    // in-window result between excursions
    wr(8'h00, 8'h00);
    wr(8'h20, 8'h40);
    bb <= 16'h0300;
    wr(8'h18, 8'h13);
    wr(8'h00, 8'h03);
    repeat (45) @(posedge pclk);
    bb <= 16'h0150;
    repeat (20) @(posedge pclk);
    bb <= 16'h0300;
    repeat (40) @(posedge pclk);
    `CHK("restart", 1'b0, int_oe)
    repeat (23) @(posedge pclk);
    `CHK("persist", 1'b1, int_oe)
    // reset in mid-run drops the pin and the results
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("rst_oe", 1'b0, int_oe)
    presetn <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h30, 8'h00);
    `CHK("rst_pwr", 1'b0, powered)
    summarize();
  end
endmodule : light_sensor_conversion_interrupt_tb
`default_nettype wire

// file: verification/sensor_front_model.sv
`default_nettype none
module sensor_front_model (
  input  wire logic        pclk,
  input  wire logic [15:0] bb_level,
  input  wire logic [15:0] ir_level,
  input  wire logic        int_out,
  input  wire logic        int_oe,
  output var  logic [15:0] broadband_sample,
  output var  logic [15:0] infrared_sample,
  output var  logic        int_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // converter outputs settle on pclk, the same clock as the core
  always_ff @(posedge pclk) begin
    broadband_sample <= bb_level;
    infrared_sample  <= ir_level;
  end
  // wired-AND line with pull-up
  assign int_line = int_oe ? int_out : 1'b1;
endmodule : sensor_front_model
`default_nettype wire
